// [rtl/rtc_flags_consts.vh]
// constants for the rtc flags/control block
// assumes a 50 MHz core clock and a 32-bit apb register bus
`ifndef RTC_FLAGS_CONSTS_VH
`define RTC_FLAGS_CONSTS_VH
// register byte addresses
`define ADDR_FLAGS       12'h000
`define ADDR_IRQ_STATUS  12'h004
`define ADDR_IRQ_MASK    12'h008
`define ADDR_TIME        12'h00C
`define ADDR_HOLD        12'h010
// flags register bit positions
`define BIT_READ_HOLD    0
`define BIT_FREEZE       1
`define BIT_BACKUP_FAIL  3
`define BIT_OSC_FAIL     4
// reset values
`define FLAGS_RESET      8'h00
`define MASK_RESET       4'h0
// interrupt status bit positions
`define IRQ_OSC_FAIL       0
`define IRQ_BACKUP_FAIL    1
`define IRQ_COPY_DONE      2
`define IRQ_BACKUP_CLEARED 3
// timing: clock rate in kHz, oscillator check window in ms, transfer time in us
`define CLK_KHZ          50000
`define OSC_CHECK_MS     5
`define OSC_CHECK_CYC    (`OSC_CHECK_MS * `CLK_KHZ)
`define TRANSFER_US      1
`define TRANSFER_CYC     ((`TRANSFER_US * `CLK_KHZ) / 1000)
// window count at which the backup level is sampled, once both synchroniser stages hold the pin
`define BACKUP_SAMPLE_CYC 32'h0000_0002
// one tick of the timekeeping counter, in cycles
`define TICK_CYC         50000000
`endif

// [rtl/sync_2ff.v]
// two-flop synchroniser for a single level
// assumes the input is asynchronous to clk
`timescale 1ns/1ns
module sync_2ff
(
    input  wire clk,
    input  wire reset_n,
    input  wire din,
    output reg  dout
);
    reg stage1;
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // sync_2ff

// [rtl/cycle_timer.v]
// down counter that pulses done once after load
// assumes load is a one-cycle pulse on the same clock
`timescale 1ns/1ns
module cycle_timer
#(
    parameter [31:0] COUNT = 32'h0000_0001
)
(
    input  wire clk,
    input  wire reset_n,
    input  wire load,
    output wire busy,
    output reg  done
);
    reg [31:0] remain;
    assign busy = (remain != 32'h0000_0000);
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            remain <= 32'h0000_0000;
            done   <= 1'b0;
        end
        else if (load)
        begin
            remain <= COUNT;
            done   <= 1'b0;
        end
        else
        begin
            done <= (remain == 32'h0000_0001);
            if (busy)
                remain <= remain - 32'h0000_0001;
        end
    end
endmodule // cycle_timer

// [rtl/rtc_flags_ctrl.v]
// flags/control register of the rtc: oscillator fail, backup fail, freeze, read hold
// assumes an apb master on core_clk; osc_running and backup_low are async pins
`timescale 1ns/1ns
`include "rtc_flags_consts.vh"
module rtc_flags_ctrl
#(
    parameter [31:0] OSC_CHECK_CYCLES = `OSC_CHECK_CYC,
    parameter [31:0] TICK_CYCLES      = `TICK_CYC
)
(
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        oscEnable,
    input  wire        oscRunning,
    input  wire        backupLow,
    output reg         irq,
    output reg         freezeActive,
    output reg  [31:0] timeCount
);
    wire oscRunSync;
    wire backupLowSync;
    wire transferBusy;
    wire transferDone;
    reg  oscillator_fail_flag;
    reg  backup_power_fail_flag;
    reg  freeze;
    reg  readHold;
    reg  [31:0] timeShadow;
    reg  [31:0] holdReg;
    reg  timeChanged;
    reg  [3:0]  irqStatus;
    reg  [3:0]  irqMask;
    reg  [31:0] checkCount;
    reg  checking;
    reg  oscSeen;
    reg  [31:0] tickCount;
    reg  copyPending;
    reg  backupClearPending;
    reg  backupLoad;
    reg  copyLoad;
    wire transferLoad;
    reg  [3:0]  irqEvents;

    sync_2ff u_sync_osc
    (
        .clk     (core_clk),
        .reset_n (reset_n),
        .din     (oscRunning),
        .dout    (oscRunSync)
    );

    sync_2ff u_sync_bkp
    (
        .clk     (core_clk),
        .reset_n (reset_n),
        .din     (backupLow),
        .dout    (backupLowSync)
    );

    // one shared timer: a copy and a backup-flag clear both wait the transfer time
    cycle_timer #(.COUNT(`TRANSFER_CYC)) u_transfer
    (
        .clk     (core_clk),
        .reset_n (reset_n),
        .load    (transferLoad),
        .busy    (transferBusy),
        .done    (transferDone)
    );

    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // packs the flags register; unused bits read as zero
    function [31:0] flags_word;
        input oscFail;
        input backupFail;
        input freezeBit;
        input holdBit;
        begin
            flags_word                   = 32'h0000_0000;
            flags_word[`BIT_OSC_FAIL]    = oscFail;
            flags_word[`BIT_BACKUP_FAIL] = backupFail;
            flags_word[`BIT_FREEZE]      = freezeBit;
            flags_word[`BIT_READ_HOLD]   = holdBit;
        end
    endfunction

    wire access  = psel && penable;
    wire wrStrb  = access && pwrite;
    wire wrFlags = wrStrb && is_addr(paddr, `ADDR_FLAGS);
    wire oscStoppedEvt = checking && !oscSeen && (checkCount == OSC_CHECK_CYCLES - 32'h0000_0001)
                         && oscEnable;
    // the synchronisers are reset as well, so the backup level is only valid once they have refilled
    wire backupFailEvt = checking && (checkCount == `BACKUP_SAMPLE_CYC) && backupLowSync;
    wire tick    = (tickCount == TICK_CYCLES - 32'h0000_0001);
    wire backupClearReq = wrFlags && !pwdata[`BIT_BACKUP_FAIL] && backup_power_fail_flag && !backupClearPending;
    // a copy is only needed when the host wrote the time while frozen
    wire copyReq        = wrFlags && freeze && !pwdata[`BIT_FREEZE] && timeChanged;
    assign transferLoad = backupLoad || copyLoad;

    // power-up check window
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            checkCount <= 32'h0000_0000;
            checking   <= 1'b1;
            oscSeen    <= 1'b0;
        end
        else if (checking)
        begin
            if (oscRunSync)
                oscSeen <= 1'b1;
            if (checkCount == OSC_CHECK_CYCLES - 32'h0000_0001)
                checking <= 1'b0;
            else
                checkCount <= checkCount + 32'h0000_0001;
        end
    end

    // oscillator-fail flag: set wins over a clear in the same cycle
    always @(posedge core_clk)
    begin
        if (!reset_n)
            oscillator_fail_flag <= 1'b0;
        else if (oscStoppedEvt)
            oscillator_fail_flag <= 1'b1;
        else if (wrFlags && !pwdata[`BIT_OSC_FAIL])
            oscillator_fail_flag <= 1'b0;
    end

    // backup-fail flag: a clear only shows once the transfer time has run out
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            backup_power_fail_flag <= 1'b0;
            backupClearPending     <= 1'b0;
            backupLoad             <= 1'b0;
        end
        else
        begin
            // a second clear while one is pending is ignored, so the timer is not restarted
            backupLoad <= backupClearReq && !backupFailEvt;
            if (backupFailEvt)
            begin
                backup_power_fail_flag <= 1'b1;
                backupClearPending     <= 1'b0;
            end
            else if (backupClearReq)
                backupClearPending <= 1'b1;
            else if (backupClearPending && transferDone)
            begin
                backup_power_fail_flag <= 1'b0;
                backupClearPending     <= 1'b0;
            end
        end
    end

    // freeze and read-hold bits; releasing freeze after a time write starts the copy
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            freeze      <= 1'b0;
            readHold    <= 1'b0;
            copyPending <= 1'b0;
            copyLoad    <= 1'b0;
        end
        else
        begin
            // the timer is shared: a copy and a backup clear started together finish together
            copyLoad <= copyReq;
            if (wrFlags)
            begin
                freeze   <= pwdata[`BIT_FREEZE];
                readHold <= pwdata[`BIT_READ_HOLD];
            end
            if (copyReq)
                copyPending <= 1'b1;
            else if (copyPending && transferDone)
                copyPending <= 1'b0;
        end
    end

    // timekeeping counter, shadow and holding register
    // the counter keeps running while frozen; only the shadow that the host reads stands still
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            tickCount   <= 32'h0000_0000;
            timeCount   <= 32'h0000_0000;
            timeShadow  <= 32'h0000_0000;
            holdReg     <= 32'h0000_0000;
            timeChanged <= 1'b0;
        end
        else
        begin
            tickCount <= tick ? 32'h0000_0000 : tickCount + 32'h0000_0001;
            if (copyPending && transferDone)
            begin
                timeCount   <= timeShadow;
                timeChanged <= 1'b0;
            end
            else if (tick && !copyPending)
                timeCount <= timeCount + 32'h0000_0001;
            if (wrStrb && is_addr(paddr, `ADDR_TIME) && freeze)
            begin
                timeShadow  <= pwdata;
                timeChanged <= 1'b1;
            end
            else if (!freeze && !copyPending)
                timeShadow <= timeCount;
            if (!readHold)
                holdReg <= timeCount;
        end
    end

    // interrupt status: write one to clear, event wins
    always @*
    begin
        irqEvents = 4'h0;
        irqEvents[`IRQ_OSC_FAIL]       = oscStoppedEvt;
        irqEvents[`IRQ_BACKUP_FAIL]    = backupFailEvt;
        irqEvents[`IRQ_COPY_DONE]      = copyPending && transferDone;
        irqEvents[`IRQ_BACKUP_CLEARED] = backupClearPending && transferDone && !backupFailEvt;
    end

    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            irqStatus    <= 4'h0;
            irqMask      <= `MASK_RESET;
            irq          <= 1'b0;
            freezeActive <= 1'b0;
        end
        else
        begin
            if (wrStrb && is_addr(paddr, `ADDR_IRQ_STATUS))
                irqStatus <= (irqStatus & ~pwdata[3:0]) | irqEvents;
            else
                irqStatus <= irqStatus | irqEvents;
            if (wrStrb && is_addr(paddr, `ADDR_IRQ_MASK))
                irqMask <= pwdata[3:0];
            irq          <= |(irqStatus & irqMask);
            freezeActive <= freeze;
        end
    end

    // apb slave: zero wait states, error on unmapped address
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            // read data is launched at the setup edge so that it stands through the access cycle
            if (psel && !penable)
            begin
                case (paddr)
                    `ADDR_FLAGS:
                        prdata <= flags_word(oscillator_fail_flag, backup_power_fail_flag, freeze, readHold);
                    `ADDR_IRQ_STATUS: prdata <= {28'h0000000, irqStatus};
                    `ADDR_IRQ_MASK:   prdata <= {28'h0000000, irqMask};
                    `ADDR_TIME:       prdata <= timeShadow;
                    `ADDR_HOLD:       prdata <= holdReg;
                    default:          pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // rtc_flags_ctrl

// [bench/rtc_flags_ctrl_asserts.sv]
// apb and timekeeping port assertions
// assumes binding into rtc_flags_ctrl, one clock, sync reset
`timescale 1ns/1ns
`include "rtc_flags_consts.vh"
module rtc_flags_ctrl_asserts
#(
    parameter [31:0] OSC_CHECK_CYCLES = 32'h0000_0014,
    parameter [31:0] TICK_CYCLES      = 32'h0000_0064
)
(
    input wire        core_clk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        oscEnable,
    input wire        oscRunning,
    input wire        backupLow,
    input wire        irq,
    input wire        freezeActive,
    input wire [31:0] timeCount
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    wire mapped = paddr == `ADDR_FLAGS || paddr == `ADDR_IRQ_STATUS || paddr == `ADDR_IRQ_MASK
                  || paddr == `ADDR_TIME || paddr == `ADDR_HOLD;
    wire done = psel && penable && pready && pwrite;
    AST_APB_ANSWER: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_READY_IDLE: assert property (!psel |=> !pready) else $error("ready without request");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped) else $error("wrong slave error");
    AST_FREEZE_WRITE: assert property (done && paddr == `ADDR_FLAGS |-> ##2
        freezeActive == $past(pwdata[`BIT_FREEZE], 2)) else $error("freeze bit not taken");
    AST_FREEZE_HOLD: assert property (freezeActive && $past(freezeActive) |->
        timeCount == $past(timeCount) || timeCount == $past(timeCount) + 32'h0000_0001)
        else $error("time counter overwritten while frozen");
    AST_IRQ_MASKED: assert property (done && paddr == `ADDR_IRQ_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq with all masked");
    AST_FLAGS_ZERO: assert property (pready && !pwrite && paddr == `ADDR_FLAGS |-> prdata[31:5] == 27'h0
        && prdata[2] == 1'b0) else $error("unused flag bits set");
endmodule // rtc_flags_ctrl_asserts
bind rtc_flags_ctrl rtc_flags_ctrl_asserts #(.OSC_CHECK_CYCLES(OSC_CHECK_CYCLES), .TICK_CYCLES(TICK_CYCLES))
    rtc_flags_ctrl_asserts_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscEnable(oscEnable), .oscRunning(oscRunning), .backupLow(backupLow), .irq(irq),
    .freezeActive(freezeActive), .timeCount(timeCount));

// [bench/apb_host_model.sv]
// apb master standing in for the host processor
// assumes the slave answers with pready; waits are cut by the bench watchdog
`timescale 1ns/1ns
module apb_host_model
(
    input  wire        core_clk,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // one transfer; oscillator and backup flags are cleared by writing zero through here
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1)
                @(posedge core_clk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // released lines must not keep looking valid
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule // apb_host_model

// [bench/rtc_flags_ctrl_tb.sv]
// self-checking bench for the rtc flags/control block
// assumes apb_host_model drives the bus; short check window and tick
`timescale 1ns/1ns
`include "rtc_flags_consts.vh"
module rtc_flags_ctrl_tb;
    reg         core_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         oscEnable = 1'b1;
    reg         oscRunning = 1'b0;
    reg         backupLow = 1'b1;
    wire        psel, penable, pwrite, pready, pslverr, irq, freezeActive;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata, timeCount;
    reg  [31:0] rd, hold;
    reg         re;
    integer     err_total = 0;
    integer     compares = 0;
    always #10 core_clk = ~core_clk;
    rtc_flags_ctrl #(.OSC_CHECK_CYCLES(32'h0000_0014), .TICK_CYCLES(32'h0000_0064)) rtc_flags_ctrl_i
        (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscEnable(oscEnable), .oscRunning(oscRunning), .backupLow(backupLow), .irq(irq),
        .freezeActive(freezeActive), .timeCount(timeCount));
    apb_host_model apb_host_model_i (.core_clk(core_clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task check(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb_host_model_i.xfer(1'b1, a, d, rd, re);
    endtask
    task rr(input [11:0] a);
        apb_host_model_i.xfer(1'b0, a, 32'h0000_0000, rd, re);
    endtask
    task power_up(input run, input low);
        begin
            @(posedge core_clk);
            reset_n <= 1'b0;
            oscRunning <= run;
            backupLow <= low;
            repeat (3) @(posedge core_clk);
            reset_n <= 1'b1;
        end
    endtask
    task final_report;
        begin
            $display("errors %0d compares %0d", err_total, compares);
            if (err_total == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        err_total = err_total + 1;
        final_report;
    end
    initial
    begin
        // dead oscillator, low backup: oscillator flag only after the window
        power_up(1'b0, 1'b1);
        rr(`ADDR_FLAGS);
        check(rd & 32'h10, 32'h00);
        repeat (30) @(posedge core_clk);
        rr(`ADDR_FLAGS);
        check(rd, 32'h18);
        rr(`ADDR_IRQ_STATUS);
        check(rd, 32'h03);
        // writing ones keeps the flag; only a zero clears it
        wr(`ADDR_FLAGS, 32'h18);
        repeat (40) @(posedge core_clk);
        rr(`ADDR_FLAGS);
        check(rd, 32'h18);
        wr(`ADDR_FLAGS, 32'h08);
        rr(`ADDR_FLAGS);
        check(rd, 32'h08);
        // backup clear shows only after the transfer time
        wr(`ADDR_FLAGS, 32'h00);
        rr(`ADDR_FLAGS);
        check(rd, 32'h08);
        repeat (60) @(posedge core_clk);
        rr(`ADDR_FLAGS);
        check(rd, 32'h00);
        rr(`ADDR_IRQ_STATUS);
        check(rd, 32'h0B);
        // mask on, mask off, mask on again, then clear
        wr(`ADDR_IRQ_MASK, 32'h8);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ_MASK, 32'h8);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_STATUS, 32'hF);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        rr(`ADDR_IRQ_STATUS);
        check(rd, 32'h0);
        // freeze, load time, release and wait for the copy
        // the shadow the host reads stands still while frozen, though the counter runs on
        wr(`ADDR_FLAGS, 32'h02);
        repeat (2) @(posedge core_clk);
        check({31'h0, freezeActive}, 32'h1);
        rr(`ADDR_TIME);
        hold = rd;
        repeat (250) @(posedge core_clk);
        rr(`ADDR_TIME);
        check(rd, hold);
        wr(`ADDR_TIME, 32'h1234);
        rr(`ADDR_TIME);
        check(rd, 32'h1234);
        wr(`ADDR_FLAGS, 32'h00);
        check({31'h0, timeCount == 32'h1234}, 32'h0);
        repeat (60) @(posedge core_clk);
        check({31'h0, timeCount - 32'h1234 <= 32'h1}, 32'h1);
        rr(`ADDR_IRQ_STATUS);
        check(rd, 32'h4);
        // read hold keeps the holding copy still
        wr(`ADDR_FLAGS, 32'h01);
        rr(`ADDR_HOLD);
        hold = rd;
        repeat (250) @(posedge core_clk);
        rr(`ADDR_HOLD);
        check(rd, hold);
        wr(`ADDR_FLAGS, 32'h00);
        repeat (250) @(posedge core_clk);
        rr(`ADDR_HOLD);
        check({31'h0, rd == hold}, 32'h0);
        // unmapped write refused and harmless
        apb_host_model_i.xfer(1'b1, 12'h020, 32'hFFFF_FFFF, rd, re);
        check({31'h0, re}, 32'h1);
        rr(`ADDR_FLAGS);
        check(rd, 32'h00);
        // second power-up with a healthy oscillator and backup
        power_up(1'b1, 1'b0);
        repeat (30) @(posedge core_clk);
        rr(`ADDR_FLAGS);
        check(rd, 32'h00);
        final_report;
    end
endmodule // rtc_flags_ctrl_tb
